// >>> hdl/tsq_consts.vh
`ifndef TSQ_CONSTS_VH
`define TSQ_CONSTS_VH

// ==========================================
// register byte offsets
`define TSQ_OFF_CONTROL 8'h00
`define TSQ_OFF_C1_LIMIT 8'h04
`define TSQ_OFF_HOLD 8'h08
`define TSQ_OFF_ADJUST 8'h0c
`define TSQ_OFF_LITERAL 8'h10
`define TSQ_OFF_QPTR 8'h14
`define TSQ_OFF_COUNTER_ONE 8'h18
`define TSQ_OFF_CHANNEL 8'h1c
`define TSQ_OFF_QUEUE_BASE 8'h40

// ==========================================
// field positions and widths
`define TSQ_CTRL_ENABLE_BIT 0
`define TSQ_CTRL_START_BIT 1
`define TSQ_REG_W 16
`define TSQ_QPTR_W 5
`define TSQ_CHAN_W 6

// ==========================================
// reset values
`define TSQ_RST_REG 16'h0000
`define TSQ_RST_QPTR 5'h00
`define TSQ_RST_CHAN 6'h00

// ==========================================
// step command codes, bits 7-4 of a step byte; the CMD3 codes match bits 7-5 only
`define TSQ_CMD_CONTROL 4'h0
`define TSQ_CMD_ADD_COPY 4'h1
`define TSQ_CMD3_STROBE 3'h1
`define TSQ_CMD3_JUMP 3'h5
`define TSQ_CMD3_JUMP_C0 3'h6
`define TSQ_CMD3_JUMP_C1 3'h7

// ==========================================
// control options and add/copy targets
`define TSQ_OPT_CHAN_C0 4'hc
`define TSQ_OPT_CHAN_C1 4'hd
`define TSQ_OPT_CHAN_LIT 4'he
`define TSQ_TGT_C0_LIMIT 3'h0
`define TSQ_TGT_C1_LIMIT 3'h1
`define TSQ_TGT_T0_LIMIT 3'h2
`define TSQ_TGT_T1_LIMIT 3'h3
`define TSQ_TGT_SD_LIMIT 3'h4
`define TSQ_TGT_LITERAL 3'h5

`endif

// >>> hdl/tsq_step_queue.v
`timescale 1ns/1ps
`default_nettype none

module tsq_step_queue #(
	parameter WORDS = 16,
	parameter IDX_W = 4
)(
	input wire clk,
	input wire writeEnable,
	input wire [IDX_W-1:0] writeIndex,
	input wire [15:0] writeData,
	input wire [IDX_W-1:0] readIndex,
	output wire [15:0] readData,
	input wire [IDX_W:0] pointer,
	output wire [7:0] fetchByte
);

	// ==========================================
	// storage, no reset term at all
	reg [15:0] mem [0:WORDS-1];
	wire [15:0] fetchWord;

	always @(posedge clk)
	begin
		if (writeEnable)
			mem[writeIndex] <= writeData;
	end

	assign readData = mem[readIndex];

	// ==========================================
	// byte fetch, even step low byte
	assign fetchWord = mem[pointer[IDX_W:1]];
	assign fetchByte = pointer[0] ? fetchWord[15:8] : fetchWord[7:0];

endmodule
`default_nettype wire

// >>> hdl/tsq_step_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "tsq_consts.vh"

module tsq_step_decode (
	input wire [7:0] stepByte,
	output wire isControl,
	output wire isAddCopy,
	output wire isStrobe,
	output wire isJump,
	output wire isJumpC0,
	output wire isJumpC1,
	output wire isCopy,
	output wire [2:0] target,
	output wire [4:0] literal5,
	output wire chanFromC0,
	output wire chanFromC1,
	output wire chanFromLit
);

	// ==========================================
	// command and option split
	wire [3:0] cmd;
	wire [3:0] opt;

	assign cmd = stepByte[7:4];
	assign opt = stepByte[3:0];

	// unknown codes match nothing and run as no-operation
	assign isControl = (cmd == `TSQ_CMD_CONTROL);
	assign isAddCopy = (cmd == `TSQ_CMD_ADD_COPY);
	assign isStrobe = (cmd[3:1] == `TSQ_CMD3_STROBE);
	assign isJump = (cmd[3:1] == `TSQ_CMD3_JUMP);
	assign isJumpC0 = (cmd[3:1] == `TSQ_CMD3_JUMP_C0);
	assign isJumpC1 = (cmd[3:1] == `TSQ_CMD3_JUMP_C1);
	assign isCopy = opt[3];
	assign target = opt[2:0];
	assign literal5 = {cmd[0], opt};
	assign chanFromC0 = isControl && (opt == `TSQ_OPT_CHAN_C0);
	assign chanFromC1 = isControl && (opt == `TSQ_OPT_CHAN_C1);
	assign chanFromLit = isControl && (opt == `TSQ_OPT_CHAN_LIT);

endmodule
`default_nettype wire

// >>> hdl/tsq_step_registers.v
`timescale 1ns/1ps
`default_nettype none
`include "tsq_consts.vh"

// Behaviour
// - sixteen-bit counter-one limit: loop count of counted jump, or counter compare limit
// - while enabled and started, all these registers except control ignore writes and stay readable
// - copy step moves the hold value into the chosen limit or literal
// - add step adds the adjust value into the chosen limit or literal
// - control step with literal source loads low six literal bits into channel select
// - five-bit queue pointer marks the active step; upper bits read zero
// - sixteen queue words, each holding steps 2x low and 2x+1 high
// - queue words keep their contents through every reset
// - power-on reset clears limit, hold, adjust, literal and pointer; all read/write
// - step byte: command in bits 7-4, option in 3-0; reserved acts as no-operation
// - counted jump: at limit advance pointer, else bump counter and jump
module tsq_step_registers #(
	parameter ADDR_W = 8,
	parameter QUEUE_WORDS = 16
)(
	input wire clk,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire stepExecute,
	input wire [15:0] counterZeroValue,
	output reg [7:0] stepByte,
	output reg [4:0] stepQueuePointer,
	output reg [5:0] conversionChannelSelect,
	output reg moduleEnableBit,
	output reg sequenceStartBit,
	output reg limitOpStrobe,
	output reg limitOpCopy,
	output reg [2:0] limitOpTarget,
	output reg [15:0] limitOpOperand
);

	// ==========================================
	// state
	reg [15:0] counterOneLimit;
	reg [15:0] holdOperand;
	reg [15:0] adjustOperand;
	reg [15:0] literalZero;
	reg [15:0] counterOne;
	reg [31:0] readValue;
	reg addrOk;

	wire running;
	wire accessPending;
	wire writeFire;
	wire writeAllowed;
	wire queueHit;
	wire queueWrite;
	wire execute;
	wire [15:0] queueReadData;
	wire [7:0] currentByte;
	wire isControl;
	wire isAddCopy;
	wire isStrobe;
	wire isJump;
	wire isJumpC0;
	wire isJumpC1;
	wire isCopy;
	wire [2:0] target;
	wire [4:0] literal5;
	wire chanFromC0;
	wire chanFromC1;
	wire chanFromLit;
	wire [15:0] opValue;
	wire [4:0] pointerPlusOne;
	wire controlWrite;

	// ==========================================
	// address decode
	localparam [ADDR_W-1:0] QUEUE_BASE = `TSQ_OFF_QUEUE_BASE;

	function isQueueAddr;
		input [ADDR_W-1:0] addr;
		begin
			isQueueAddr = (addr[ADDR_W-1:6] == QUEUE_BASE[ADDR_W-1:6]) && (addr[1:0] == 2'h0);
		end
	endfunction

	// ==========================================
	// copy replaces, add sums into the target
	function [15:0] applyOp;
		input copy;
		input [15:0] current;
		input [15:0] holdValue;
		input [15:0] adjustValue;
		begin
			applyOp = copy ? holdValue : current + adjustValue;
		end
	endfunction

	assign running = moduleEnableBit && sequenceStartBit;
	assign accessPending = psel && penable && !pready;
	assign writeFire = psel && penable && pready && pwrite && addrOk;
	assign writeAllowed = writeFire && !running;
	assign queueHit = isQueueAddr(paddr);
	assign queueWrite = writeAllowed && queueHit;
	assign execute = stepExecute && running;
	assign pointerPlusOne = stepQueuePointer + 5'h01;

	// ==========================================
	// control bits stay writable while running
	assign controlWrite = writeFire && (paddr == `TSQ_OFF_CONTROL);

	// ==========================================
	// queue storage and step decode
	tsq_step_queue #(
		.WORDS(QUEUE_WORDS),
		.IDX_W(4)
	) queue (
		.clk(clk),
		.writeEnable(queueWrite),
		.writeIndex(paddr[5:2]),
		.writeData(pwdata[15:0]),
		.readIndex(paddr[5:2]),
		.readData(queueReadData),
		.pointer(stepQueuePointer),
		.fetchByte(currentByte)
	);

	tsq_step_decode decode (
		.stepByte(currentByte),
		.isControl(isControl),
		.isAddCopy(isAddCopy),
		.isStrobe(isStrobe),
		.isJump(isJump),
		.isJumpC0(isJumpC0),
		.isJumpC1(isJumpC1),
		.isCopy(isCopy),
		.target(target),
		.literal5(literal5),
		.chanFromC0(chanFromC0),
		.chanFromC1(chanFromC1),
		.chanFromLit(chanFromLit)
	);

	assign opValue = isCopy ? holdOperand : adjustOperand;

	// ==========================================
	// read mux
	always @*
	begin
		readValue = 32'h0000_0000;
		addrOk = 1'b1;
		case (paddr)
			`TSQ_OFF_CONTROL:
				readValue = {30'h0000_0000, sequenceStartBit, moduleEnableBit};
			`TSQ_OFF_C1_LIMIT:
				readValue = {16'h0000, counterOneLimit};
			`TSQ_OFF_HOLD:
				readValue = {16'h0000, holdOperand};
			`TSQ_OFF_ADJUST:
				readValue = {16'h0000, adjustOperand};
			`TSQ_OFF_LITERAL:
				readValue = {16'h0000, literalZero};
			`TSQ_OFF_QPTR:
				readValue = {27'h000_0000, stepQueuePointer};
			`TSQ_OFF_COUNTER_ONE:
				readValue = {16'h0000, counterOne};
			`TSQ_OFF_CHANNEL:
				readValue = {26'h000_0000, conversionChannelSelect};
			default:
			begin
				if (queueHit)
					readValue = {16'h0000, queueReadData};
				else
					addrOk = 1'b0;
			end
		endcase
	end

	// ==========================================
	// apb answer, one wait state
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= accessPending;
			if (accessPending)
			begin
				prdata <= readValue;
				pslverr <= !addrOk;
			end
			else
				pslverr <= 1'b0;
		end
	end

	// ==========================================
	// fetched step for the interpreter
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			stepByte <= 8'h00;
		else
			stepByte <= currentByte;
	end

	// ==========================================
	// registers and step execution
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			moduleEnableBit <= 1'b0;
			sequenceStartBit <= 1'b0;
			counterOneLimit <= `TSQ_RST_REG;
			holdOperand <= `TSQ_RST_REG;
			adjustOperand <= `TSQ_RST_REG;
			literalZero <= `TSQ_RST_REG;
			stepQueuePointer <= `TSQ_RST_QPTR;
			counterOne <= `TSQ_RST_REG;
			conversionChannelSelect <= `TSQ_RST_CHAN;
			limitOpStrobe <= 1'b0;
			limitOpCopy <= 1'b0;
			limitOpTarget <= 3'h0;
			limitOpOperand <= 16'h0000;
		end
		else
		begin
			limitOpStrobe <= 1'b0;
			if (!moduleEnableBit)
				counterOne <= `TSQ_RST_REG;
			if (controlWrite)
			begin
				moduleEnableBit <= pwdata[`TSQ_CTRL_ENABLE_BIT];
				sequenceStartBit <= pwdata[`TSQ_CTRL_START_BIT];
			end
			if (writeAllowed)
			begin
				case (paddr)
					`TSQ_OFF_C1_LIMIT:
						counterOneLimit <= pwdata[15:0];
					`TSQ_OFF_HOLD:
						holdOperand <= pwdata[15:0];
					`TSQ_OFF_ADJUST:
						adjustOperand <= pwdata[15:0];
					`TSQ_OFF_LITERAL:
						literalZero <= pwdata[15:0];
					`TSQ_OFF_QPTR:
						stepQueuePointer <= pwdata[4:0];
					default:
					begin
					end
				endcase
			end
			else if (execute)
			begin
				stepQueuePointer <= pointerPlusOne;
				if (isAddCopy)
				begin
					if (target == `TSQ_TGT_C1_LIMIT)
						counterOneLimit <= applyOp(isCopy, counterOneLimit, holdOperand, adjustOperand);
					else if (target == `TSQ_TGT_LITERAL)
						literalZero <= applyOp(isCopy, literalZero, holdOperand, adjustOperand);
					else if (target <= `TSQ_TGT_SD_LIMIT)
					begin
						limitOpStrobe <= 1'b1;
						limitOpCopy <= isCopy;
						limitOpTarget <= target;
						limitOpOperand <= opValue;
					end
				end
				if (isStrobe)
					conversionChannelSelect <= {1'b0, literal5};
				if (chanFromLit)
					conversionChannelSelect <= literalZero[5:0];
				if (chanFromC1)
					conversionChannelSelect <= counterOne[5:0];
				if (chanFromC0)
					conversionChannelSelect <= counterZeroValue[5:0];
				if (isJumpC0)
					stepQueuePointer <= pointerPlusOne;
				if (isJump)
					stepQueuePointer <= literal5;
				if (isJumpC1)
				begin
					if (counterOne != counterOneLimit)
					begin
						counterOne <= counterOne + 16'h0001;
						stepQueuePointer <= literal5;
					end
				end
			end
		end
	end

endmodule
`default_nettype wire

// >>> testbench/tsq_step_registers_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsq_consts.vh"
// ==========================================
// step register checker
module tsq_step_registers_props #(
	parameter ADDR_W = 8,
	parameter QUEUE_WORDS = 16
)(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic stepExecute,
	input wire logic [7:0] stepByte,
	input wire logic [4:0] stepQueuePointer,
	input wire logic [5:0] conversionChannelSelect,
	input wire logic moduleEnableBit,
	input wire logic sequenceStartBit,
	input wire logic limitOpStrobe,
	input wire logic limitOpCopy,
	input wire logic [2:0] limitOpTarget
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	wire logic run = moduleEnableBit && sequenceStartBit;
	wire logic acc = psel && penable && pready;
	wire logic ptrWr = acc && pwrite && paddr == `TSQ_OFF_QPTR;
	sequence s_exec;
		stepExecute && run && $stable(stepQueuePointer);
	endsequence
	property p_ptr_read;
		acc && !pwrite && paddr == `TSQ_OFF_QPTR |-> prdata[31:5] == 27'h0000000;
	endproperty
	property p_reset_ptr;
		$rose(reset_n) |-> stepQueuePointer == `TSQ_RST_QPTR && !moduleEnableBit;
	endproperty
	property p_locked_ptr;
		ptrWr && run && !stepExecute |=> $stable(stepQueuePointer);
	endproperty
	property p_ptr_write;
		ptrWr && !run |=> stepQueuePointer == $past(pwdata[4:0]);
	endproperty
	property p_copy;
		s_exec ##0 (stepByte[7:3] == 5'h03 && stepByte[2:0] != 3'h1 && stepByte[2:0] < 3'h5)
			|=> limitOpStrobe && limitOpCopy && limitOpTarget == $past(stepByte[2:0]);
	endproperty
	property p_add;
		s_exec ##0 (stepByte[7:3] == 5'h02 && stepByte[2:0] != 3'h1 && stepByte[2:0] < 3'h5)
			|=> limitOpStrobe && !limitOpCopy && limitOpTarget == $past(stepByte[2:0]);
	endproperty
	property p_jump_one;
		s_exec ##0 (stepByte[7:5] == 3'h7)
			|=> stepQueuePointer == $past(stepQueuePointer) + 5'h01
			|| stepQueuePointer == $past(stepByte[4:0]);
	endproperty
	property p_reserved;
		s_exec ##0 (stepByte[7:4] == 4'h6)
			|=> stepQueuePointer == $past(stepQueuePointer) + 5'h01
			&& $stable(conversionChannelSelect);
	endproperty
	property p_strobe;
		s_exec ##0 (stepByte[7:5] == 3'h1)
			|=> conversionChannelSelect == {1'b0, $past(stepByte[4:0])};
	endproperty
	a_ptr_read: assert property (p_ptr_read) else $error("pointer upper bits not zero");
	a_reset_ptr: assert property (p_reset_ptr) else $error("pointer not cleared by reset");
	a_locked_ptr: assert property (p_locked_ptr) else $error("locked pointer written");
	a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");
	a_copy: assert property (p_copy) else $error("copy step wrong");
	a_add: assert property (p_add) else $error("add step wrong");
	a_jump_one: assert property (p_jump_one) else $error("counted jump wrong");
	a_reserved: assert property (p_reserved) else $error("reserved step not a no-op");
	a_strobe: assert property (p_strobe) else $error("strobe channel wrong");
endmodule

bind tsq_step_registers tsq_step_registers_props #(.ADDR_W(ADDR_W), .QUEUE_WORDS(QUEUE_WORDS)) i_props (
	.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .stepExecute(stepExecute),
	.stepByte(stepByte), .stepQueuePointer(stepQueuePointer),
	.conversionChannelSelect(conversionChannelSelect), .moduleEnableBit(moduleEnableBit),
	.sequenceStartBit(sequenceStartBit), .limitOpStrobe(limitOpStrobe),
	.limitOpCopy(limitOpCopy), .limitOpTarget(limitOpTarget));
`default_nettype wire

// >>> testbench/test_tsq_step_registers.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// step register bench
module test_tsq_step_registers;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stepExecute = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rdData;
	logic pready, pslverr, limitOpStrobe, limitOpCopy, moduleEnableBit, sequenceStartBit, err;
	logic [7:0] stepByte;
	logic [4:0] stepQueuePointer;
	logic [5:0] conversionChannelSelect;
	logic [2:0] limitOpTarget;
	logic [15:0] limitOpOperand;
	logic [15:0] prog [0:6] = '{16'h141a, 16'h600e, 16'h2be4, 16'h1915, 16'h0c0d, 16'h2fac, 16'h00c3};
	logic [15:0] counterZero = 16'h0027;
	int nErrors = 0, numChecks = 0;
	tsq_step_registers i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stepExecute(stepExecute), .counterZeroValue(counterZero),
		.stepByte(stepByte), .stepQueuePointer(stepQueuePointer),
		.conversionChannelSelect(conversionChannelSelect), .moduleEnableBit(moduleEnableBit),
		.sequenceStartBit(sequenceStartBit), .limitOpStrobe(limitOpStrobe),
		.limitOpCopy(limitOpCopy), .limitOpTarget(limitOpTarget), .limitOpOperand(limitOpOperand));
	initial forever #2 clk = ~clk;
	initial
	begin
		#80000;
		nErrors++;
		final_report();
	end
	// ==========================================
	// tasks
	task automatic final_report();
		$display("checks %0d mismatches %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp)
		begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk);
		end
		rdData = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
			chk("bus answer", 32'h00000001, 32'h00000000);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk("read data", exp, rdData);
	endtask
	task automatic step(input logic [4:0] ptr, input logic [20:0] op);
		@(posedge clk);
		stepExecute <= 1'b1;
		@(posedge clk);
		stepExecute <= 1'b0;
		#1;
		chk("limit op", {11'h000, op}, op[20] ? {11'h000, limitOpStrobe, limitOpCopy, limitOpTarget,
			limitOpOperand} : {31'h00000000, limitOpStrobe});
		chk("pointer", {27'h0000000, ptr}, {27'h0000000, stepQueuePointer});
		@(posedge clk);
		#1;
		chk("step byte", {24'h000000, ptr[0] ? prog[ptr[4:1]][15:8] : prog[ptr[4:1]][7:0]},
			{24'h000000, stepByte});
	endtask
	// ==========================================
	// tests
	initial
	begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++) apb(1'b1, 8'h04 + 8'(4 * i), 32'hffffffff);
		for (int i = 0; i < 5; i++) rd(8'h04 + 8'(4 * i), i == 4 ? 32'h0000001f : 32'h0000ffff);
		for (int i = 0; i < 7; i++) apb(1'b1, 8'h40 + 8'(4 * i), {16'hffff, prog[i]});
		rd(8'h44, 32'h0000600e);
		apb(1'b0, 8'h3c, 32'h00000000);
		chk("unmapped error", 32'h00000001, {31'h00000000, err});
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++) rd(8'h04 + 8'(4 * i), 32'h00000000);
		rd(8'h40, 32'h0000141a);
		apb(1'b1, 8'h08, 32'h00001234);
		apb(1'b1, 8'h0c, 32'h00000005);
		apb(1'b1, 8'h10, 32'h0000002b);
		apb(1'b1, 8'h04, 32'h00000001);
		apb(1'b1, 8'h00, 32'h00000003);
		apb(1'b1, 8'h08, 32'h00007777);
		apb(1'b1, 8'h40, 32'h00000000);
		apb(1'b1, 8'h14, 32'h00000009);
		rd(8'h08, 32'h00001234);
		rd(8'h40, 32'h0000141a);
		rd(8'h14, 32'h00000000);
		chk("slave error", 32'h00000000, {31'h0, err});
		chk("run bits", 32'h00000003, {30'h0, sequenceStartBit, moduleEnableBit});
		step(5'h01, {1'b1, 1'b1, 3'h2, 16'h1234});
		step(5'h02, {1'b1, 1'b0, 3'h4, 16'h0005});
		step(5'h03, 21'h000000);
		chk("channel", 32'h0000002b, {26'h0000000, conversionChannelSelect});
		step(5'h04, 21'h000000);
		step(5'h04, 21'h000000);
		step(5'h05, 21'h000000);
		step(5'h06, 21'h000000);
		chk("channel", 32'h0000000b, {26'h0000000, conversionChannelSelect});
		step(5'h07, 21'h000000);
		step(5'h08, 21'h000000);
		step(5'h09, 21'h000000);
		chk("channel", 32'h00000001, {26'h0000000, conversionChannelSelect});
		step(5'h0a, 21'h000000);
		chk("channel", 32'h00000027, {26'h0000000, conversionChannelSelect});
		step(5'h0c, 21'h000000);
		step(5'h0d, 21'h000000);
		apb(1'b1, 8'h00, 32'h00000001);
		rd(8'h10, 32'h00000030);
		rd(8'h04, 32'h00001234);
		chk("run bits", 32'h00000001, {30'h0, sequenceStartBit, moduleEnableBit});
		final_report();
	end
endmodule
`default_nettype wire
